// ---- shared/gpw_consts.svh ----
// Purpose: constants for the port block (offsets, fields, resets)
// Assumes: special function register byte addresses on an 8-bit core bus
// Notes: included by the main design file only; the package does not include it
// Summary of operation
// RULE1: three 8-bit ports, bit-accessible, 0 1 3
// RULE2: port data at 0x80, 0x90, 0xB0
// RULE3: read-modify-write reads return the output latch
// RULE4: other reads return the sensed pin level
// RULE5: logic, jump-clear, complement, inc/dec, bit moves are rmw
// RULE6: drive enabled pin outputs latch, input sees it
// RULE7: undriven with pull-up select is weak-high input
// RULE8: undriven without pull-up is plain high-impedance input
// RULE9: software should clear pull-up on output pins
// RULE10: wake-enabled gpio pins can wake the device; here a set wake bit masks its pin, and pins with the bit clear wake
// RULE11: wake term per pin, all ANDed onto irq two
// RULE12: software services irq two for pin wakes
// RULE13: per-port pull-up, drive and wake enable registers
// RULE14: serial0 pad select makes pad open drain
// RULE15: twowire pad select makes pads open drain
// RULE16: baseband pad direction bit: one output, zero input
// RULE17: clock pad select hands pad to clock
// RULE18: analog pad select hands pad to converter
// RULE19: pin inputs pass two flip-flops first
`ifndef GPW_CONSTS_SVH
`define GPW_CONSTS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define GPW_ADDR_P0_DATA 8'h80
`define GPW_ADDR_P1_DATA 8'h90
`define GPW_ADDR_P3_DATA 8'hB0
`define GPW_ADDR_P3_WEAK 8'hAA
`define GPW_ADDR_P3_DRV 8'hAB
`define GPW_ADDR_P3_WAKE 8'hAC
`define GPW_ADDR_P0_WEAK 8'hB2
`define GPW_ADDR_P0_DRV 8'hB3
`define GPW_ADDR_P0_WAKE 8'hB4
`define GPW_ADDR_P1_WEAK 8'hB5
`define GPW_ADDR_P1_DRV 8'hB6
`define GPW_ADDR_P1_WAKE 8'hB7
`define GPW_ADDR_PAD_SEL 8'hBB
// ----------------------------------------
// pad select fields and reset values
// ----------------------------------------
`define GPW_SEL_SERIAL0 0
`define GPW_SEL_TWOWIRE 1
`define GPW_SEL_BASEBAND 3
`define GPW_SEL_CLOCK 4
`define GPW_SEL_ANALOG 5
`define GPW_SEL_MASK 8'h3B
`define GPW_RESET_BYTE 8'h00
`endif

// ---- shared/gpw_pkg.sv ----
// Purpose: types for the port block
// Assumes: constants come from gpw_consts.svh
// Notes: port index encoding used by the main file
package gpw_pkg;
  typedef enum {
    GPW_PORT0,
    GPW_PORT1,
    GPW_PORT3
  } gpw_port_t;
  typedef logic [7:0] gpw_byte_t;
endpackage

// ---- logic/gpw_sync.sv ----
// Purpose: two-flop synchroniser for one pin byte
// Assumes: asynchronous pin levels, one core clock
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module gpw_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  // ----------------------------------------
  // two stages
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle pulled level, so the wake line sees no false low after reset
      meta_r <= '1;
      sync_out <= '1;
    end else begin
      meta_r <= async_in; // RULE19
      sync_out <= meta_r;
    end
  end
endmodule // gpw_sync
`default_nettype wire

// ---- logic/gpw_pad.sv ----
// Purpose: per-pin pad mode for one 8-bit port
// Assumes: drive, pull-up and latch come from registers
// Notes: open-drain bits drive low only
`timescale 1ns/1ps
`default_nettype none
module gpw_pad #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] drive_en,
  input wire logic [WIDTH-1:0] weak_en,
  input wire logic [WIDTH-1:0] open_drain,
  input wire logic [WIDTH-1:0] released,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pad_pull
);
  // ----------------------------------------
  // per-bit mode table
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      if (released[i]) begin
        pad_out[i] = 1'b0;
        pad_oe[i] = 1'b0;
        pad_pull[i] = 1'b0; // RULE17 RULE18
      end else if (open_drain[i]) begin
        pad_out[i] = 1'b0;
        pad_oe[i] = ~latch[i]; // RULE14 RULE15
        pad_pull[i] = weak_en[i];
      end else begin
        pad_out[i] = latch[i]; // RULE6
        pad_oe[i] = drive_en[i];
        pad_pull[i] = weak_en[i] & ~drive_en[i]; // RULE7 RULE8
      end
    end
  end
endmodule // gpw_pad
`default_nettype wire

// ---- logic/gpw_ports.sv ----
// Purpose: three 8-bit gpio ports with wake and pad select
// Assumes: core presents an sfr bus and flags rmw reads
// Notes: outputs registered; pad values computed then flopped
// Notes: pin reads lag the pins by two clocks; pads lag writes by two
`timescale 1ns/1ps
`default_nettype none
`include "gpw_consts.svh"
module gpw_ports
  import gpw_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [7:0] SERIAL0_PAD_MASK = 8'h01,
  parameter logic [7:0] TWOWIRE_PAD_MASK = 8'h0C,
  parameter logic [7:0] BASEBAND_PAD_MASK = 8'h10,
  parameter logic [7:0] CLOCK_PAD_MASK = 8'h20,
  parameter logic [7:0] ANALOG_PAD_MASK = 8'h40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic [WIDTH-1:0] p0_in,
  input wire logic [WIDTH-1:0] p1_in,
  input wire logic [WIDTH-1:0] p3_in,
  output logic [WIDTH-1:0] p0_out,
  output logic [WIDTH-1:0] p0_oe,
  output logic [WIDTH-1:0] p0_pull,
  output logic [WIDTH-1:0] p1_out,
  output logic [WIDTH-1:0] p1_oe,
  output logic [WIDTH-1:0] p1_pull,
  output logic [WIDTH-1:0] p3_out,
  output logic [WIDTH-1:0] p3_oe,
  output logic [WIDTH-1:0] p3_pull,
  output logic external_irq_two,
  output logic baseband_pad_direction,
  output logic clock_pad_select,
  output logic analog_pad_select
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] data_r [3];
  logic [7:0] weak_r [3];
  logic [7:0] drv_r [3];
  logic [7:0] wake_r [3];
  logic [7:0] sel_r;
  logic [7:0] pin_input_value [3];
  logic [7:0] pad_out_c [3];
  logic [7:0] pad_oe_c [3];
  logic [7:0] pad_pull_c [3];
  logic [7:0] wake_term [3];
  logic [7:0] od_c [3];
  logic [7:0] rel_c [3];
  logic [7:0] rd_nxt;
  logic hit_nxt;
  gpw_port_t wsel;
  logic wsel_ok;
  logic [1:0] wkind;

  // ----------------------------------------
  // synchronisers and pads
  // ----------------------------------------
  gpw_sync #(.WIDTH(WIDTH)) u_sync0 (.clk(clk), .rst_n(rst_n), .async_in(p0_in), .sync_out(pin_input_value[0]));
  gpw_sync #(.WIDTH(WIDTH)) u_sync1 (.clk(clk), .rst_n(rst_n), .async_in(p1_in), .sync_out(pin_input_value[1]));
  gpw_sync #(.WIDTH(WIDTH)) u_sync3 (.clk(clk), .rst_n(rst_n), .async_in(p3_in), .sync_out(pin_input_value[2]));

  // pad functions sit on port 3 only; masks are placement guesses
  // baseband pad keeps port behaviour; only its direction leaves the block
  always_comb begin
    od_c[0] = 8'h00;
    od_c[1] = 8'h00;
    rel_c[0] = 8'h00;
    rel_c[1] = 8'h00;
    od_c[2] = (sel_r[`GPW_SEL_SERIAL0] ? SERIAL0_PAD_MASK : 8'h00)
            | (sel_r[`GPW_SEL_TWOWIRE] ? TWOWIRE_PAD_MASK : 8'h00);
    rel_c[2] = (sel_r[`GPW_SEL_CLOCK] ? CLOCK_PAD_MASK : 8'h00)
             | (sel_r[`GPW_SEL_ANALOG] ? ANALOG_PAD_MASK : 8'h00);
  end

  for (genvar p = 0; p < 3; p++) begin : g_port
    gpw_pad #(.WIDTH(WIDTH)) u_pad (
      .latch(data_r[p]),
      .drive_en(drv_r[p]),
      .weak_en(weak_r[p]),
      .open_drain(od_c[p]),
      .released(rel_c[p]),
      .pad_out(pad_out_c[p]),
      .pad_oe(pad_oe_c[p]),
      .pad_pull(pad_pull_c[p])
    );
    // wake term is one when wake enable set, else the pin
    assign wake_term[p] = wake_r[p] | pin_input_value[p]; // RULE11
  end

  // ----------------------------------------
  // address decode for writes
  // ----------------------------------------
  always_comb begin
    wsel = GPW_PORT0;
    wsel_ok = 1'b1;
    wkind = 2'd0;
    case (sfr_addr)
      `GPW_ADDR_P0_DATA: begin wsel = GPW_PORT0; wkind = 2'd0; end
      `GPW_ADDR_P1_DATA: begin wsel = GPW_PORT1; wkind = 2'd0; end
      `GPW_ADDR_P3_DATA: begin wsel = GPW_PORT3; wkind = 2'd0; end
      `GPW_ADDR_P0_WEAK: begin wsel = GPW_PORT0; wkind = 2'd1; end
      `GPW_ADDR_P1_WEAK: begin wsel = GPW_PORT1; wkind = 2'd1; end
      `GPW_ADDR_P3_WEAK: begin wsel = GPW_PORT3; wkind = 2'd1; end
      `GPW_ADDR_P0_DRV: begin wsel = GPW_PORT0; wkind = 2'd2; end
      `GPW_ADDR_P1_DRV: begin wsel = GPW_PORT1; wkind = 2'd2; end
      `GPW_ADDR_P3_DRV: begin wsel = GPW_PORT3; wkind = 2'd2; end
      `GPW_ADDR_P0_WAKE: begin wsel = GPW_PORT0; wkind = 2'd3; end
      `GPW_ADDR_P1_WAKE: begin wsel = GPW_PORT1; wkind = 2'd3; end
      `GPW_ADDR_P3_WAKE: begin wsel = GPW_PORT3; wkind = 2'd3; end
      default: wsel_ok = 1'b0;
    endcase
  end

  // byte write or single-bit write into one of the port's registers
  function automatic logic [7:0] upd(input logic [7:0] old);
    logic [7:0] v;
    v = old;
    if (sfr_wr) begin
      v = sfr_wdata;
    end else if (sfr_bit_wr) begin
      v[sfr_bit_sel] = sfr_bit_val; // RULE1 RULE2
    end
    return v;
  endfunction

  // ----------------------------------------
  // port registers
  // ----------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_regs
    logic hit_p;
    assign hit_p = wsel_ok && (int'(wsel) == p) && (sfr_wr || sfr_bit_wr);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        data_r[p] <= `GPW_RESET_BYTE;
      end else if (hit_p && wkind == 2'd0) begin
        data_r[p] <= upd(data_r[p]); // RULE1
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        weak_r[p] <= `GPW_RESET_BYTE;
      end else if (hit_p && wkind == 2'd1) begin
        weak_r[p] <= upd(weak_r[p]); // RULE13
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        drv_r[p] <= `GPW_RESET_BYTE;
      end else if (hit_p && wkind == 2'd2) begin
        drv_r[p] <= upd(drv_r[p]); // RULE13
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        wake_r[p] <= `GPW_RESET_BYTE;
      end else if (hit_p && wkind == 2'd3) begin
        wake_r[p] <= upd(wake_r[p]); // RULE13
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= `GPW_RESET_BYTE;
    end else if (sfr_addr == `GPW_ADDR_PAD_SEL && (sfr_wr || sfr_bit_wr)) begin
      sel_r <= upd(sel_r) & `GPW_SEL_MASK;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // rmw instructions see the latch so that untouched bits keep the
  // written value even where the pin is pulled the other way
  function automatic logic [7:0] port_view(input int p);
    return sfr_rmw ? data_r[p] : pin_input_value[p]; // RULE3 RULE4 RULE5
  endfunction

  always_comb begin
    rd_nxt = 8'h00;
    hit_nxt = 1'b1;
    case (sfr_addr)
      `GPW_ADDR_P0_DATA: rd_nxt = port_view(0);
      `GPW_ADDR_P1_DATA: rd_nxt = port_view(1);
      `GPW_ADDR_P3_DATA: rd_nxt = port_view(2);
      `GPW_ADDR_P0_WEAK: rd_nxt = weak_r[0];
      `GPW_ADDR_P1_WEAK: rd_nxt = weak_r[1];
      `GPW_ADDR_P3_WEAK: rd_nxt = weak_r[2];
      `GPW_ADDR_P0_DRV: rd_nxt = drv_r[0];
      `GPW_ADDR_P1_DRV: rd_nxt = drv_r[1];
      `GPW_ADDR_P3_DRV: rd_nxt = drv_r[2];
      `GPW_ADDR_P0_WAKE: rd_nxt = wake_r[0];
      `GPW_ADDR_P1_WAKE: rd_nxt = wake_r[1];
      `GPW_ADDR_P3_WAKE: rd_nxt = wake_r[2];
      `GPW_ADDR_PAD_SEL: rd_nxt = sel_r;
      default: hit_nxt = 1'b0;
    endcase
  end

  // data forced to zero between reads so a stale byte is never taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= sfr_rd ? rd_nxt : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= sfr_rd & hit_nxt;
    end
  end

  // ----------------------------------------
  // registered pad and wake outputs
  // ----------------------------------------
  // one extra cycle of latency on pads, traded for clean outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_out <= '0;
      p0_oe <= '0;
      p0_pull <= '0;
    end else begin
      p0_out <= pad_out_c[0]; // RULE6
      p0_oe <= pad_oe_c[0];
      p0_pull <= pad_pull_c[0]; // RULE7 RULE8
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_out <= '0;
      p1_oe <= '0;
      p1_pull <= '0;
    end else begin
      p1_out <= pad_out_c[1];
      p1_oe <= pad_oe_c[1];
      p1_pull <= pad_pull_c[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p3_out <= '0;
      p3_oe <= '0;
      p3_pull <= '0;
    end else begin
      p3_out <= pad_out_c[2];
      p3_oe <= pad_oe_c[2];
      p3_pull <= pad_pull_c[2];
    end
  end

  // reset high, and the syncs reset high, so no false wake follows reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      external_irq_two <= 1'b1;
    end else begin
      // low means some pin pulled the shared line; wakes the core
      external_irq_two <= &{wake_term[0], wake_term[1], wake_term[2]}; // RULE10 RULE11
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baseband_pad_direction <= 1'b0;
    end else begin
      baseband_pad_direction <= sel_r[`GPW_SEL_BASEBAND]; // RULE16
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_pad_select <= 1'b0;
    end else begin
      clock_pad_select <= sel_r[`GPW_SEL_CLOCK]; // RULE17
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_pad_select <= 1'b0;
    end else begin
      analog_pad_select <= sel_r[`GPW_SEL_ANALOG]; // RULE18
    end
  end
endmodule // gpw_ports
`default_nettype wire

// ---- tb/gpw_board.sv ----
// Purpose: board-level pins of one port
// Assumes: outside drive never fights a driving pad
// Notes: bare lines toggle so a stale level never passes
`timescale 1ns/1ps
`default_nettype none
module gpw_board (
  input wire logic clk,
  input wire logic [7:0] o,
  input wire logic [7:0] oe,
  input wire logic [7:0] pu,
  input wire logic [7:0] ee,
  input wire logic [7:0] ev,
  output logic [7:0] p
);
  logic [7:0] f_r = 8'h55;
  // bare lines move on the falling edge, off the sampling edge
  always_ff @(negedge clk) f_r <= ~f_r;
  assign p = (oe & o) | (~oe & ee & ev) | (~oe & ~ee & (pu | f_r));
endmodule // gpw_board
`default_nettype wire

// ---- tb/gpw_ports_sva.sv ----
// Purpose: checker for the port block
// Assumes: sees the top ports only
// Notes: pin reads judged once the syncs have filled
`timescale 1ns/1ps
`default_nettype none
module gpw_ports_sva #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic sfr_bit_val,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic sfr_hit,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic [WIDTH-1:0] p0_in,
  input wire logic [WIDTH-1:0] p1_in,
  input wire logic [WIDTH-1:0] p3_in,
  input wire logic [WIDTH-1:0] p0_out,
  input wire logic [WIDTH-1:0] p0_oe,
  input wire logic [WIDTH-1:0] p0_pull,
  input wire logic [WIDTH-1:0] p1_out,
  input wire logic [WIDTH-1:0] p1_oe,
  input wire logic [WIDTH-1:0] p1_pull,
  input wire logic [WIDTH-1:0] p3_out,
  input wire logic [WIDTH-1:0] p3_oe,
  input wire logic [WIDTH-1:0] p3_pull,
  input wire logic external_irq_two,
  input wire logic baseband_pad_direction,
  input wire logic clock_pad_select,
  input wire logic analog_pad_select
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [1:0] up_r;
  logic hi, m;
  assign hi = &{p0_in, p1_in, p3_in};
  assign m = sfr_addr inside {8'h80, 8'h90, 8'hB0, 8'hAA, 8'hAB, 8'hAC, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hBB};
  // syncs still hold reset values just after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  property sel_p;
    logic [2:0] v;
    (sfr_wr && sfr_addr == 8'hBB, v = sfr_wdata[5:3])
      |=> ##1 {analog_pad_select, clock_pad_select, baseband_pad_direction} == v;
  endproperty
  map_hit_a: assert property (sfr_rd && m |=> sfr_hit)
    else $error("no hit");
  unmapped_read_a: assert property (sfr_rd && !m |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read");
  rmw_latch_a: assert property (sfr_rd && sfr_rmw && sfr_addr == 8'h80 && !sfr_wr && !sfr_bit_wr
    |=> ##1 p0_out == $past(sfr_rdata)) else $error("rmw read");
  pin_read_a: assert property (up_r == 2'h3 && sfr_rd && !sfr_rmw && sfr_addr == 8'h90 && $stable(p1_in)
    && p1_in == $past(p1_in, 2) |=> sfr_rdata == $past(p1_in)) else $error("pin read");
  drive_en_a: assert property (sfr_wr && sfr_addr == 8'hB3 |=> ##1 p0_oe == $past(sfr_wdata, 2))
    else $error("drive enable");
  weak_high_a: assert property (sfr_wr && sfr_addr == 8'hB5
    |=> ##1 ((p1_pull ^ $past(sfr_wdata, 2)) & ~p1_oe) == 8'h00) else $error("pull");
  pad_sel_a: assert property (sel_p)
    else $error("pad select");
  wake_idle_a: assert property (hi [*3] |=> external_irq_two)
    else $error("irq low");
  wake_cause_a: assert property (up_r == 2'h3 && !external_irq_two |-> !$past(hi, 3))
    else $error("irq cause");
  cover property (sfr_rd && sfr_rmw);
  cover property (!external_irq_two);
  cover property (sfr_wr && sfr_addr == 8'hBB);
endmodule // gpw_ports_sva
bind gpw_ports gpw_ports_sva #(.WIDTH(WIDTH)) u_gpw_ports_sva (.*);
`default_nettype wire

// ---- tb/gpw_ports_tb.sv ----
// Purpose: bench for the port block
// Assumes: board models drive the pins
// Notes: bus inputs and board drive move on falling edges; pins also follow pad outputs after rising edges
`timescale 1ns/1ps
`default_nettype none
module gpw_ports_tb;
  logic clk, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_rmw, sfr_hit, external_irq_two;
  logic baseband_pad_direction, clock_pad_select, analog_pad_select;
  logic [2:0] sfr_bit_sel;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, p0_in, p1_in, p3_in, p0_out, p0_oe, p0_pull;
  logic [7:0] p1_out, p1_oe, p1_pull, p3_out, p3_oe, p3_pull;
  logic [7:0] e1 = '0, v1 = '0, e3 = '0, v3 = '0;
  logic [7:0] cfg [10] = '{8'hAA, 8'hAB, 8'hAC, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hBB};
  int n_fail, comparisons;
  gpw_ports u_gpw_ports (.*);
  gpw_board u_gpw_board_0 (.clk, .o(p0_out), .oe(p0_oe), .pu(p0_pull), .ee(8'h00), .ev(8'h00), .p(p0_in));
  gpw_board u_gpw_board_1 (.clk, .o(p1_out), .oe(p1_oe), .pu(p1_pull), .ee(e1), .ev(v1), .p(p1_in));
  gpw_board u_gpw_board_3 (.clk, .o(p3_out), .oe(p3_oe), .pu(p3_pull), .ee(e3), .ev(v3), .p(p3_in));
  task automatic ck(input logic [8:0] g, input logic [8:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  // bit writes carry index in d[2:0], value in d[3]
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'b0);
    @(negedge clk);
    {sfr_addr, sfr_wdata, sfr_bit_sel, sfr_bit_val} = {a, d, d[2:0], d[3]};
    {sfr_wr, sfr_bit_wr} = {!b, b};
    @(negedge clk);
    {sfr_wr, sfr_bit_wr} = 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [8:0] e);
    @(negedge clk);
    {sfr_addr, sfr_rmw, sfr_rd} = {a, m, 1'b1};
    @(negedge clk);
    sfr_rd = 1'b0;
    ck({sfr_hit, sfr_rdata}, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic test_done;
    $display("fails %0d checks %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    for (int i = 0; i < 10; i++) rd(cfg[i], 1'b0, 9'h100);
    rd(8'h80, 1'b1, 9'h100);
    for (int i = 0; i < 10; i++) wr(cfg[i], 8'hA5);
    for (int i = 0; i < 10; i++) rd(cfg[i], 1'b0, (i == 9) ? 9'h121 : 9'h1A5);
    for (int i = 0; i < 10; i++) wr(cfg[i], 8'h00);
    wr(8'hB6, 8'h0F, 1'b1);
    rd(8'hB6, 1'b0, 9'h180);
    wr(8'hB6, 8'h07, 1'b1);
    rd(8'hB6, 1'b0, 9'h100);
    wr(8'h81, 8'hFF);
    rd(8'h81, 1'b0, 9'h000);
    rd(8'h80, 1'b1, 9'h100);
    $display("regs done");
  endtask
  task automatic t_drive;
    wr(8'hB3, 8'hFF);
    wr(8'h80, 8'h5A);
    wr(8'h80, 8'h08, 1'b1);
    wr(8'h80, 8'h03, 1'b1);
    wr(8'hB2, 8'hFF);
    wt(3);
    ck(9'(p0_out), 9'h053);
    ck(9'(p0_oe), 9'h0FF);
    ck(9'(p0_pull), 9'h000);
    rd(8'h80, 1'b1, 9'h153);
    rd(8'h80, 1'b0, 9'h153);
    wr(8'hB2, 8'h00);
    $display("drive done");
  endtask
  task automatic t_input;
    wr(8'h90, 8'hAA);
    e1 = 8'hFF;
    v1 = 8'hC3;
    wt(3);
    rd(8'h90, 1'b1, 9'h1AA);
    ck(9'(p1_out), 9'h0AA);
    rd(8'h90, 1'b0, 9'h1C3);
    ck(9'(p1_oe), 9'h000);
    e1 = 8'h00;
    wr(8'hB5, 8'hFF);
    wt(3);
    ck(9'(p1_pull), 9'h0FF);
    rd(8'h90, 1'b0, 9'h1FF);
    wr(8'hB5, 8'h00);
    e1 = 8'hFF;
    v1 = 8'h96;
    wt(3);
    rd(8'h90, 1'b0, 9'h196);
    $display("input done");
  endtask
  task automatic t_wake;
    wr(8'h80, 8'hFF);
    v1 = 8'hFF;
    e3 = 8'hFF;
    v3 = 8'hFF;
    wt(4);
    ck(9'(external_irq_two), 9'h001);
    v3 = 8'hFB;
    wt(4);
    ck(9'(external_irq_two), 9'h000);
    wr(8'hAC, 8'h04);
    wt(4);
    ck(9'(external_irq_two), 9'h001);
    $display("wake done");
  endtask
  task automatic t_pads;
    e3 = 8'h00;
    wr(8'hAA, 8'hFF);
    wr(8'hAB, 8'h40);
    wr(8'hBB, 8'h3B);
    wt(2);
    ck(9'({analog_pad_select, clock_pad_select, baseband_pad_direction}), 9'h007);
    ck(9'(p3_pull & 8'h6D), 9'h00D);
    ck(9'(p3_oe & 8'h4D), 9'h00D);
    ck(9'(p3_out & 8'h0D), 9'h000);
    wr(8'hB0, 8'hFF);
    wt(2);
    ck(9'(p3_oe & 8'h0D), 9'h000);
    wr(8'hBB, 8'h00);
    wt(2);
    ck(9'(p3_oe & 8'h4D), 9'h040);
    ck(9'(p3_out & 8'h0D), 9'h00D);
    ck(9'({analog_pad_select, clock_pad_select}), 9'h000);
    wr(8'hBB, 8'h0C, 1'b1);
    wt(2);
    ck(9'(clock_pad_select), 9'h001);
    $display("pads done");
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    n_fail++;
    $display("FAIL %0t timeout", $time);
    test_done;
  end
  initial begin
    {rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_rmw, sfr_bit_sel, sfr_addr, sfr_wdata} = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_regs;
    t_drive;
    t_input;
    t_wake;
    t_pads;
    test_done;
  end
endmodule // gpw_ports_tb
`default_nettype wire
